// ---- rtl/sfwp_pkg.sv ----
// Constants and types for the serial flash write-protection block
package sfwp_pkg;
   localparam int unsigned OP_W      = 8;
   localparam int unsigned ADDR_W    = 24;
   localparam int unsigned CNT_W     = 12;
   localparam int unsigned BLK_N     = 64;
   localparam int unsigned BLK_LSB   = 16;
   localparam int unsigned BLK_W     = 6;
   localparam int unsigned OTP_W     = 9;
   localparam int unsigned RA_W      = 4;
   // Frame lengths in bits
   localparam logic [CNT_W-1:0] LEN_OP   = 12'h008;
   localparam logic [CNT_W-1:0] LEN_ADDR = 12'h020;
   localparam logic [CNT_W-1:0] LEN_DATA = 12'h028;
   localparam logic [CNT_W-1:0] QUAD_STEP = 12'h004;
   // Command opcodes
   localparam logic [7:0] OP_SET_WRITE_LATCH   = 8'h06;
   localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
   localparam logic [7:0] OP_PAGE_PROGRAM      = 8'h02;
   localparam logic [7:0] OP_AUTO_INC_PROGRAM  = 8'had;
   localparam logic [7:0] OP_SECTOR_WIPE       = 8'h20;
   localparam logic [7:0] OP_BLOCK_ERASE       = 8'hd8;
   localparam logic [7:0] OP_CHIP_ERASE_A      = 8'h60;
   localparam logic [7:0] OP_CHIP_ERASE_B      = 8'hc7;
   localparam logic [7:0] OP_DEEP_POWERDOWN    = 8'hb9;
   localparam logic [7:0] OP_WAKE_OR_SIGNATURE = 8'hab;
   localparam logic [7:0] OP_LOCK_BLOCK        = 8'he2;
   localparam logic [7:0] OP_CHIP_UNLOCK       = 8'hf3;
   localparam logic [7:0] OP_QUAD_READ         = 8'heb;
   localparam logic [7:0] OP_ENTER_OTP         = 8'hb1;
   localparam logic [7:0] OP_LEAVE_OTP         = 8'hc1;
   localparam logic [7:0] OP_WRITE_LOCK_REG    = 8'h2f;
   localparam logic [7:0] OP_READ_SECURITY     = 8'h2b;
   // Array operation kinds
   localparam logic [1:0] ARR_PROGRAM = 2'h0;
   localparam logic [1:0] ARR_SECTOR  = 2'h1;
   localparam logic [1:0] ARR_BLOCK   = 2'h2;
   localparam logic [1:0] ARR_CHIP    = 2'h3;
   // OTP layout
   localparam logic [OTP_W-1:0] OTP_SERIAL_LAST = 9'h00f;
   localparam int unsigned SEC_FACTORY_BIT = 0;
   localparam int unsigned SEC_CUSTOMER_BIT = 1;
   // Register map
   localparam logic [RA_W-1:0] REG_STATUS  = 4'h0;
   localparam logic [RA_W-1:0] REG_LOCK_LO = 4'h4;
   localparam logic [RA_W-1:0] REG_LOCK_HI = 4'h8;
   localparam logic [RA_W-1:0] REG_CTRL    = 4'hc;
   localparam int unsigned ST_WEL_BIT  = 0;
   localparam int unsigned ST_DPD_BIT  = 1;
   localparam int unsigned ST_OTP_BIT  = 2;
   localparam int unsigned ST_QUAD_BIT = 3;
   localparam int unsigned ST_SEC_LSB  = 4;
   localparam int unsigned CTRL_COMMIT_BIT = 0;

   typedef struct packed {
      logic spare_or_io3;
      logic protect_or_io2;
      logic io1_data_out;
      logic io0_data_in;
   } sfwp_pads_t;

   typedef struct packed {
      logic              otp;
      logic [1:0]        kind;
      logic [ADDR_W-1:0] addr;
   } sfwp_arr_op_t;

   typedef enum logic [1:0] {ST_STANDBY, ST_OPCODE, ST_BODY, ST_IGNORE} sfwp_state_t;
endpackage

// ---- rtl/sfwp_core.sv ----
// Command filter and write protection for a quad-capable serial flash
//
// Functional notes
// [R1] Reset puts command engine in standby
// [R2] Array changes only after whole valid frame
// [R3] Frame must end on byte boundary
// [R4] Write latch needed for altering commands
// [R5] Latch cleared by reset and listed commands
// [R6] Deep power-down passes only wake, signature
// [R7] Lock command locks block from A21-A16
// [R8] Chip unlock clears every block lock
// [R9] Protect pin low protects every block
// [R10] Pin high: per-block lock state governs
// [R11] Four-line read disables pin protection
// [R12] Security bit 0 shows factory lock
// [R13] Write-lock command sets security bit 1
// [R14] Lock bits can never be cleared
// [R15] OTP programmed between enter and leave
// [R16] OTP mode blocks main array access
// [R17] OTP: serial 000-00F, customer 010-1FF
// [R18] Line 0 in, line 1 out, single mode
// [R19] Protect pin doubles as data line 2
// [R20] Spare pin is data line 3 only
// [R21] 1024 sectors, 64 blocks of 64 KB
// [R22] Sample on rising, shift on falling
// [R23] Refused writes leave array untouched
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
module sfwp_core
   import sfwp_pkg::*;
#(
   parameter logic [7:0] SIGNATURE = 8'h5a  // Arbitrary identification value
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic         cs_n,
   input  wire logic         sclk,
   input  wire sfwp_pads_t   pad_in,
   output      sfwp_pads_t   pad_out,
   output      sfwp_pads_t   pad_oe_n,
   input  wire logic         factory_lock_strap,
   output      sfwp_arr_op_t arr_op,
   output      logic         arr_go,
   input  wire logic [RA_W-1:0] reg_addr,
   input  wire logic [31:0]  reg_wdata,
   input  wire logic         reg_wr,
   input  wire logic         reg_rd,
   output      logic [31:0]  reg_rdata
);
   localparam int unsigned NSYNC = 4;

   function automatic logic is_program(input logic [7:0] op);
      return op == OP_PAGE_PROGRAM || op == OP_AUTO_INC_PROGRAM;
   endfunction

   function automatic logic is_erase(input logic [7:0] op);
      return op == OP_SECTOR_WIPE || op == OP_BLOCK_ERASE ||
             op == OP_CHIP_ERASE_A || op == OP_CHIP_ERASE_B;
   endfunction

   // Three-stage input filter: cs_n, sclk, line 0, line 2
   logic [NSYNC-1:0] s1_q, s2_q, s3_q, flt_q, flt_prev_q;
   wire  [NSYNC-1:0] raw = {pad_in.protect_or_io2, pad_in.io0_data_in, sclk, cs_n};

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_q       <= '1;
         s2_q       <= '1;
         s3_q       <= '1;
         flt_q      <= '1;
         flt_prev_q <= '1;
      end else begin
         s1_q       <= raw;
         s2_q       <= s1_q;
         s3_q       <= s2_q;
         flt_prev_q <= flt_q;
         for (int i = 0; i < NSYNC; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               flt_q[i] <= s3_q[i];
            end
         end
      end
   end

   wire cs_fall   = flt_prev_q[0] && !flt_q[0];
   wire cs_rise   = !flt_prev_q[0] && flt_q[0];
   wire sck_rise  = !flt_q[0] && !flt_prev_q[1] && flt_q[1];
   wire sck_fall  = !flt_q[0] && flt_prev_q[1] && !flt_q[1];
   wire din       = flt_q[2];
   wire wp_level  = flt_q[3];

   // Frame capture
   sfwp_state_t       state_q;
   logic [CNT_W-1:0]  bits_q;
   logic [7:0]        op_q;
   logic [ADDR_W-1:0] addr_q;
   logic              quad_q;
   logic              wel_q, dpd_q, otp_q;
   logic              factory_q, cust_q, init_q;
   logic [BLK_N-1:0]  lock_q;
   logic              commit_en_q;
   logic [7:0]        out_sr_q;
   logic              reply_q;

   wire [7:0] op_next = {op_q[6:0], din};
   wire       op_done = state_q == ST_OPCODE && sck_rise && bits_q == LEN_OP - 12'h001;
   wire       op_pass = !dpd_q || op_next == OP_WAKE_OR_SIGNATURE;  // [R6]

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= ST_STANDBY;  // [R1]
      end else begin
         case (state_q)
            ST_STANDBY: if (cs_fall) state_q <= ST_OPCODE;
            ST_OPCODE: begin
               if (cs_rise) begin
                  state_q <= ST_STANDBY;
               end else if (op_done) begin
                  state_q <= op_pass ? ST_BODY : ST_IGNORE;  // [R6]
               end
            end
            ST_BODY, ST_IGNORE: if (cs_rise) state_q <= ST_STANDBY;
            default: state_q <= ST_STANDBY;
         endcase
      end
   end

   // Bit count, opcode and address shift; quad frames take four bits per edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bits_q <= '0;
         op_q   <= '0;
         addr_q <= '0;
         quad_q <= 1'b0;
      end else if (cs_fall) begin
         bits_q <= '0;
         quad_q <= 1'b0;
         // A stale address must not leak into a frame that carries none
         addr_q <= '0;
      end else if (cs_rise) begin
         quad_q <= 1'b0;  // [R11]
      end else if (sck_rise && state_q != ST_STANDBY) begin  // [R22]
         bits_q <= (bits_q == '1) ? bits_q : bits_q + (quad_q ? QUAD_STEP : 12'h001);
         if (state_q == ST_OPCODE) begin
            op_q <= op_next;  // [R18]
            if (op_done && op_next == OP_QUAD_READ) begin
               quad_q <= 1'b1;  // [R19] [R20]
            end
         end else if (bits_q < LEN_ADDR && !quad_q) begin
            addr_q <= {addr_q[ADDR_W-2:0], din};
         end
      end
   end

   // Frame end decode
   logic frame_ok, has_addr, has_data, hw_prot, blk_locked, any_locked;
   logic otp_ok, arr_ok, alter, go_arr;
   logic [OTP_W-1:0] otp_off;

   always_comb begin
      frame_ok   = cs_rise && state_q == ST_BODY &&
                   bits_q[2:0] == 3'h0 && bits_q >= LEN_OP;  // [R3] [R2]
      has_addr   = bits_q >= LEN_ADDR;
      has_data   = bits_q >= LEN_DATA;
      hw_prot    = !wp_level && !quad_q;  // [R9] [R11]
      blk_locked = lock_q[addr_q[BLK_LSB+BLK_W-1:BLK_LSB]];  // [R7] [R10] [R21]
      any_locked = |lock_q;
      otp_off    = addr_q[OTP_W-1:0];
      // Serial field guarded by factory bit, the rest by customer bit
      otp_ok     = (otp_off > OTP_SERIAL_LAST) ? !cust_q : !factory_q;  // [R17]
      alter      = is_program(op_q) || is_erase(op_q) || op_q == OP_LOCK_BLOCK ||
                   op_q == OP_CHIP_UNLOCK || op_q == OP_WRITE_LOCK_REG;
      arr_ok     = 1'b0;
      if (is_program(op_q)) begin
         arr_ok = has_data && (otp_q ? otp_ok : !(hw_prot || blk_locked));  // [R15]
      end else if (op_q == OP_SECTOR_WIPE || op_q == OP_BLOCK_ERASE) begin
         arr_ok = has_addr && !otp_q && !(hw_prot || blk_locked);  // [R16]
      end else if (is_erase(op_q)) begin
         arr_ok = !otp_q && !hw_prot && !any_locked;
      end
      go_arr     = frame_ok && wel_q && arr_ok && commit_en_q;  // [R4] [R23]
   end

   // Write enable latch
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wel_q <= 1'b0;  // [R5]
      end else if (frame_ok) begin
         if (op_q == OP_SET_WRITE_LATCH) begin
            wel_q <= 1'b1;
         end else if (op_q == OP_CLEAR_WRITE_LATCH || is_program(op_q) || is_erase(op_q)) begin
            wel_q <= 1'b0;  // [R5]
         end
      end
   end

   // Power-down and OTP mode
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dpd_q <= 1'b0;
         otp_q <= 1'b0;
      end else if (frame_ok) begin
         if (op_q == OP_DEEP_POWERDOWN) begin
            dpd_q <= 1'b1;
         end else if (op_q == OP_WAKE_OR_SIGNATURE) begin
            dpd_q <= 1'b0;  // [R6]
         end
         if (op_q == OP_ENTER_OTP) begin
            otp_q <= 1'b1;  // [R15]
         end else if (op_q == OP_LEAVE_OTP) begin
            otp_q <= 1'b0;  // [R15]
         end
      end
   end

   // Block locks
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lock_q <= '0;
      end else if (frame_ok && wel_q) begin  // [R4]
         if (op_q == OP_LOCK_BLOCK && has_addr && !otp_q) begin
            lock_q[addr_q[BLK_LSB+BLK_W-1:BLK_LSB]] <= 1'b1;  // [R7]
         end else if (op_q == OP_CHIP_UNLOCK) begin
            lock_q <= '0;  // [R8]
         end
      end
   end

   // Security bits; strap caught once after reset release
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         init_q    <= 1'b0;
         factory_q <= 1'b0;
         cust_q    <= 1'b0;
      end else begin
         init_q <= 1'b1;
         if (!init_q) begin
            factory_q <= factory_lock_strap;  // [R12]
         end
         if (frame_ok && wel_q && op_q == OP_WRITE_LOCK_REG) begin
            cust_q <= 1'b1;  // [R13] [R14]
         end
      end
   end

   // Array request
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         arr_go <= 1'b0;
         arr_op <= '0;
      end else begin
         arr_go <= go_arr;  // [R2]
         if (go_arr) begin
            arr_op.otp  <= otp_q;  // [R16]
            arr_op.addr <= otp_q ? ADDR_W'(otp_off) : addr_q;
            case (op_q)
               OP_SECTOR_WIPE: arr_op.kind <= ARR_SECTOR;
               OP_BLOCK_ERASE: arr_op.kind <= ARR_BLOCK;
               OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: arr_op.kind <= ARR_CHIP;
               default: arr_op.kind <= ARR_PROGRAM;
            endcase
         end
      end
   end

   // Reply on line 1, shifted on the falling clock edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reply_q  <= 1'b0;
         out_sr_q <= '0;
         pad_out  <= '0;
         pad_oe_n <= '1;
      end else if (cs_rise || cs_fall) begin
         reply_q      <= 1'b0;
         pad_oe_n     <= '1;
      end else if (op_done && op_pass &&
                   (op_next == OP_READ_SECURITY || op_next == OP_WAKE_OR_SIGNATURE)) begin
         reply_q  <= 1'b1;
         out_sr_q <= (op_next == OP_READ_SECURITY) ?
                     {6'h00, cust_q, factory_q} : SIGNATURE;  // [R12] [R13]
      end else if (reply_q && sck_fall) begin
         pad_out.io1_data_out  <= out_sr_q[7];  // [R22] [R18]
         pad_oe_n.io1_data_out <= 1'b0;
         out_sr_q              <= {out_sr_q[6:0], out_sr_q[7]};
      end
   end

   // Register port
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         commit_en_q <= 1'b1;
      end else if (reg_wr && reg_addr == REG_CTRL) begin
         commit_en_q <= reg_wdata[CTRL_COMMIT_BIT];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= '0;
         if (reg_rd) begin
            case (reg_addr)
               REG_STATUS: begin
                  reg_rdata[ST_WEL_BIT]  <= wel_q;
                  reg_rdata[ST_DPD_BIT]  <= dpd_q;
                  reg_rdata[ST_OTP_BIT]  <= otp_q;
                  reg_rdata[ST_QUAD_BIT] <= quad_q;
                  reg_rdata[ST_SEC_LSB+SEC_FACTORY_BIT]  <= factory_q;
                  reg_rdata[ST_SEC_LSB+SEC_CUSTOMER_BIT] <= cust_q;
               end
               REG_LOCK_LO: reg_rdata <= lock_q[31:0];
               REG_LOCK_HI: reg_rdata <= lock_q[63:32];
               REG_CTRL:    reg_rdata[CTRL_COMMIT_BIT] <= commit_en_q;
               default:     reg_rdata <= '0;
            endcase
         end
      end
   end

   // Checks
   sequence s_frame_end;
      cs_rise && state_q == ST_BODY;
   endsequence

   sequence s_prog_done;
      s_frame_end ##0 frame_ok && is_program(op_q);
   endsequence

   a_wel_cleared: assert property (@(posedge clk) disable iff (!rstn)  // [R5]
      s_prog_done |=> !wel_q) else $error("latch not cleared after program");

   a_go_needs_wel: assert property (@(posedge clk) disable iff (!rstn)  // [R4]
      arr_go |-> $past(wel_q)) else $error("array write without latch");

   a_pin_protects: assert property (@(posedge clk) disable iff (!rstn)  // [R9]
      arr_go && !arr_op.otp |-> $past(wp_level)) else $error("write while pin low");

   a_byte_length: assert property (@(posedge clk) disable iff (!rstn)  // [R3]
      arr_go |-> $past(bits_q[2:0]) == 3'h0) else $error("partial byte accepted");

   a_dpd_filter: assert property (@(posedge clk) disable iff (!rstn)  // [R6]
      dpd_q && op_done && op_next != OP_WAKE_OR_SIGNATURE |=> state_q == ST_IGNORE)
      else $error("command passed in power-down");

   a_cust_sticky: assert property (@(posedge clk) disable iff (!rstn)  // [R14]
      cust_q |=> cust_q[*8]) else $error("customer lock cleared");

   a_factory_sticky: assert property (@(posedge clk) disable iff (!rstn)  // [R14]
      init_q ##1 $changed(factory_q) |-> 1'b0) else $error("factory lock changed");

   a_otp_only: assert property (@(posedge clk) disable iff (!rstn)  // [R16]
      arr_go && $past(otp_q) |-> arr_op.otp && arr_op.kind == ARR_PROGRAM)
      else $error("array reached in OTP mode");

   a_locked_block: assert property (@(posedge clk) disable iff (!rstn)  // [R10]
      arr_go && !arr_op.otp && arr_op.kind != ARR_CHIP |->
      !$past(lock_q[addr_q[BLK_LSB+BLK_W-1:BLK_LSB]])) else $error("locked block written");

   a_unlock_all: assert property (@(posedge clk) disable iff (!rstn)  // [R8]
      s_frame_end ##0 (frame_ok && wel_q && op_q == OP_CHIP_UNLOCK) |=> lock_q == '0)
      else $error("unlock left a block locked");

   a_back_standby: assert property (@(posedge clk) disable iff (!rstn)  // [R1]
      cs_rise |=> state_q == ST_STANDBY ##1 state_q != ST_BODY)
      else $error("engine not in standby after frame");

endmodule // sfwp_core

// ---- verification/sfwp_host_model.sv ----
// Host serial controller model: drives select, serial clock and data line 0
`timescale 1ns/1ps
module sfwp_host_model (
   input  wire logic       clk,
   input  wire logic       io1,
   output logic            cs_n,
   output logic            sclk,
   output logic            io0,
   output logic [7:0]      rx
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      io0  = 1'b0;
      rx   = 8'h00;
   end

   // Clock stands low between frames; 4 clk per phase gives the 200 ns link period
   task automatic send(input logic [63:0] v, input int n);
      int i;
      @(posedge clk);
      cs_n <= 1'b0;
      repeat (4) @(posedge clk);
      for (i = 63; i > 63 - n; i--) begin
         io0 <= v[i];
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         repeat (4) @(posedge clk);
         // Filtered reply lags the pin by several clocks; take it just before the fall
         rx   <= {rx[6:0], io1};
         sclk <= 1'b0;
      end
      repeat (4) @(posedge clk);
      cs_n <= 1'b1;
      // Released line shows the inverse, never a convenient stale value
      io0  <= ~io0;
      repeat (24) @(posedge clk);             // frame spacing
   endtask
endmodule // sfwp_host_model

// ---- verification/sfwp_core_tb_top.sv ----
// Self-checking testbench for the serial flash write-protection core
`timescale 1ns/1ps
module sfwp_core_tb_top;
   import sfwp_pkg::*;
   typedef struct {
      logic       write_enable_latch;
      logic [7:0] op;
      logic [23:0] addr;
      int         n;
      logic       go;
      logic [1:0] kind;
   } sfwp_row_t;

   logic         clk = 1'b0;
   logic         rstn = 1'b0;
   logic         prot = 1'b1;
   logic         strap = 1'b1;
   logic [RA_W-1:0] reg_addr = '0;
   logic [31:0]  reg_wdata = '0;
   logic         reg_wr = 1'b0;
   logic         reg_rd = 1'b0;
   logic [31:0]  reg_rdata;
   logic         cs_n, sclk, io0, io1_w;
   sfwp_pads_t   pad_in, pad_out, pad_oe_n;
   sfwp_arr_op_t arr_op, last_op;
   logic         arr_go;
   logic [7:0]   go_cnt = 8'h00;
   logic [7:0]   rx;
   localparam logic [7:0] SIG_EXP = 8'h5a;  // Arbitrary identification value
   int           error_cnt = 0;
   int           n_compared = 0;
   sfwp_row_t    rows [10] = '{
      '{1'b1, 8'h02, 24'h012345, 40, 1'b1, 2'h0}, '{1'b1, 8'had, 24'h020000, 40, 1'b1, 2'h0},
      '{1'b1, 8'h20, 24'h031000, 32, 1'b1, 2'h1}, '{1'b1, 8'hd8, 24'h3f0000, 32, 1'b1, 2'h2},
      '{1'b1, 8'h60, 24'h000000, 8, 1'b1, 2'h3}, '{1'b1, 8'hc7, 24'h000000, 8, 1'b1, 2'h3},
      '{1'b1, 8'h02, 24'h012345, 39, 1'b0, 2'h0}, '{1'b1, 8'h02, 24'h012345, 32, 1'b0, 2'h0},
      '{1'b0, 8'h02, 24'h012345, 40, 1'b0, 2'h0}, '{1'b0, 8'h20, 24'h031000, 32, 1'b0, 2'h1}};

   always #12.5 clk = ~clk;

   // Released reply line shows the inverse, so a late enable cannot pass
   assign io1_w = pad_oe_n.io1_data_out ? ~pad_out.io1_data_out : pad_out.io1_data_out;
   assign pad_in = '{spare_or_io3: 1'b1, protect_or_io2: prot,
                     io1_data_out: io1_w, io0_data_in: io0};

   sfwp_host_model host_u (.clk(clk), .io1(io1_w), .cs_n(cs_n), .sclk(sclk), .io0(io0),
                           .rx(rx));

   sfwp_core #(.SIGNATURE(SIG_EXP)) dut_u (
      .clk(clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .pad_in(pad_in), .pad_out(pad_out),
      .pad_oe_n(pad_oe_n), .factory_lock_strap(strap), .arr_op(arr_op), .arr_go(arr_go),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));

   always @(posedge clk) begin
      if (arr_go === 1'b1) begin
         go_cnt  <= go_cnt + 8'h01;
         last_op <= arr_op;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: got 0x%h expected 0x%h", $time, got, exp);
      end
   endtask

   task automatic reg_read(input logic [RA_W-1:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic reg_write(input logic [RA_W-1:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic chk_reg(input logic [RA_W-1:0] a, input logic [31:0] exp);
      logic [31:0] d;
      reg_read(a, d);
      chk(d, exp);
   endtask

   // Sends one frame and checks how many array operations it produced
   task automatic frame(input logic [7:0] op, input logic [23:0] a, input int n,
                        input logic go, input logic [26:0] exp_op);
      logic [7:0] c0;
      c0 = go_cnt;
      host_u.send({op, a, 8'ha5, 24'h000000}, n);
      chk({24'h0, go_cnt - c0}, {31'h0, go});
      if (go)
         chk({5'h0, last_op}, {5'h0, exp_op});
   endtask

   task automatic tally_and_finish();
      if (error_cnt == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      #(25.0 * 60000);
      error_cnt++;
      tally_and_finish();
   end

   initial begin
      logic [31:0] st;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      chk_reg(REG_STATUS, 32'h00000010);
      chk_reg(4'h2, 32'h0);
      chk_reg(REG_LOCK_LO, 32'h0);
      chk_reg(REG_CTRL, 32'h1);
      foreach (rows[i]) begin
         if (rows[i].write_enable_latch)
            frame(OP_SET_WRITE_LATCH, 24'h0, 8, 1'b0, '0);
         frame(rows[i].op, rows[i].addr, rows[i].n, rows[i].go,
               {1'b0, rows[i].kind, rows[i].addr});
         // Any whole-byte program or erase frame completes and uses up the latch
         chk_reg(REG_STATUS, {27'h0, 1'b1, 3'h0, rows[i].write_enable_latch && (rows[i].n % 8 != 0)});
         frame(OP_CLEAR_WRITE_LATCH, 24'h0, 8, 1'b0, '0);
         chk_reg(REG_STATUS, 32'h00000010);
      end
      // Lock block 5 from A21-A16, then program inside it and next to it
      frame(OP_SET_WRITE_LATCH, 24'h0, 8, 1'b0, '0);
      frame(OP_LOCK_BLOCK, 24'h050000, 32, 1'b0, '0);
      chk_reg(REG_LOCK_LO, 32'h00000020);
      frame(OP_PAGE_PROGRAM, 24'h050010, 40, 1'b0, '0);
      // A refused write still completes and uses up the latch
      frame(OP_SET_WRITE_LATCH, 24'h0, 8, 1'b0, '0);
      frame(OP_CHIP_ERASE_A, 24'h0, 8, 1'b0, '0);
      frame(OP_SET_WRITE_LATCH, 24'h0, 8, 1'b0, '0);
      frame(OP_PAGE_PROGRAM, 24'h060010, 40, 1'b1, {3'h0, 24'h060010});
      frame(OP_SET_WRITE_LATCH, 24'h0, 8, 1'b0, '0);
      frame(OP_CHIP_UNLOCK, 24'h0, 8, 1'b0, '0);
      chk_reg(REG_LOCK_LO, 32'h0);
      // Pin low protects every main-array block
      prot <= 1'b0;
      frame(OP_PAGE_PROGRAM, 24'h050010, 40, 1'b0, '0);
      frame(OP_QUAD_READ, 24'h0, 32, 1'b0, '0);
      prot <= 1'b1;
      frame(OP_CLEAR_WRITE_LATCH, 24'h0, 8, 1'b0, '0);
      // Power-down filters every other opcode
      frame(OP_DEEP_POWERDOWN, 24'h0, 8, 1'b0, '0);
      frame(OP_SET_WRITE_LATCH, 24'h0, 8, 1'b0, '0);
      chk_reg(REG_STATUS, 32'h00000012);
      frame(OP_WAKE_OR_SIGNATURE, 24'h0, 16, 1'b0, '0);
      chk({24'h0, rx}, {24'h0, SIG_EXP});
      chk_reg(REG_STATUS, 32'h00000010);
      // Secured area: program customer part, then lock it for good
      frame(OP_ENTER_OTP, 24'h0, 8, 1'b0, '0);
      chk_reg(REG_STATUS, 32'h00000014);
      frame(OP_SET_WRITE_LATCH, 24'h0, 8, 1'b0, '0);
      frame(OP_PAGE_PROGRAM, 24'h000005, 40, 1'b0, '0);
      frame(OP_SET_WRITE_LATCH, 24'h0, 8, 1'b0, '0);
      frame(OP_SECTOR_WIPE, 24'h031000, 32, 1'b0, '0);
      frame(OP_SET_WRITE_LATCH, 24'h0, 8, 1'b0, '0);
      frame(OP_PAGE_PROGRAM, 24'h000020, 40, 1'b1, {3'h4, 24'h000020});
      frame(OP_SET_WRITE_LATCH, 24'h0, 8, 1'b0, '0);
      frame(OP_WRITE_LOCK_REG, 24'h0, 8, 1'b0, '0);
      frame(OP_PAGE_PROGRAM, 24'h000020, 40, 1'b0, '0);
      frame(OP_READ_SECURITY, 24'h0, 16, 1'b0, '0);
      chk({24'h0, rx}, 32'h00000003);
      reg_write(REG_STATUS, 32'h0);
      frame(OP_LEAVE_OTP, 24'h0, 8, 1'b0, '0);
      chk_reg(REG_STATUS, 32'h00000030);
      // Commit disabled: no operation issued, latch still consumed
      reg_write(REG_CTRL, 32'h0);
      frame(OP_SET_WRITE_LATCH, 24'h0, 8, 1'b0, '0);
      frame(OP_PAGE_PROGRAM, 24'h012345, 40, 1'b0, '0);
      reg_read(REG_STATUS, st);
      chk(st, 32'h00000030);
      chk_reg(REG_CTRL, 32'h0);
      tally_and_finish();
   end
endmodule // sfwp_core_tb_top
